// >>> core/irig_time_code_decoder.sv
// Purpose: Serial time code decoder with disciplined time base, holdover, date keeping and watchdog.
// Assumes: Modulated input arrives as a digital envelope level; inputs synchronous to clk_sys.
// Notes: Registers over classic Wishbone; the date and time base survive a watchdog reset.
//
// Overview of operation
// - Decode A133 and A132 modulated codes; only A133 yields seconds of day.
// - Decode A003 and A002 level-shift codes; only A003 yields seconds of day.
// - Decode B123 and B122 modulated codes; only B123 yields seconds of day.
// - Decode B003 and B002 level-shift codes; only B003 yields seconds of day.
// - Decode year-bearing B007, B006, B127, B126; seconds of day for B007, B127.
// - Decode the AFNOR code and extract its full calendar date.
// - For IEEE1344 read date, zone offset, daylight saving and leap second bits.
// - Decode C37.118 like IEEE1344 with the offset sign bit inverted.
// - Only the input matching the selected code is processed; the other is ignored.
// - Host selects code and UTC offset; the device holds and applies them.
// - Losing the reference switches to the crystal time base in holdover.
// - While synchronized keep the time base within 5 us of the reference marker.
// - Date and time survive a device reset, as if kept by the backup clock.
// - A watchdog issues a device reset when software stops kicking it.
// - The host may set the running time and the date.
// - Once per second, for codes without year, compare received day with stored date; mismatch means holdover.
// - A telegram failing the consistency check sends the clock to holdover.
`timescale 1ns/1ns
module irig_time_code_decoder
    import irig_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES,
    parameter int TICK_B = TICK_B_CYCLES,
    parameter int WDT_LEN = WDT_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic am_env,
    input wire logic dcls_in,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic pps,
    output logic synced,
    output logic holdover,
    output logic wdt_reset
);
    typedef enum logic {HUNT, FRAME} frame_e;
    typedef struct packed {
        code_e code;
        logic [15:0] offset;
        logic [SUBSEC_W-1:0] subsec;
        logic [SUBSEC_W-1:0] since_rise;
        date_s now;
        frame_e state;
        logic [6:0] idx;
        logic prev_mark;
        logic frm_err;
        logic [99:0] bits;
        logic [16:0] sbs;
        logic [22:0] cf;
        logic synced;
        logic holdover;
        logic holdover_good;
        logic check_err;
        logic day_mis;
        logic phase_ok;
        logic [11:0] sync_secs;
        logic [1:0] nolock_secs;
        logic [31:0] wdt_cnt;
        logic wdt_fire;
        logic pps;
        logic ack;
        logic [31:0] rdata;
    } state_s;

    state_s s;
    state_s n;
    logic cls_valid;
    sym_e cls_sym;
    logic cls_rise;
    logic cls_lost;
    logic sec_tick;
    logic [6:0] rx_s;
    logic [6:0] rx_m;
    logic [6:0] rx_h;
    logic [8:0] rx_doy;
    logic [6:0] rx_year;
    logic rx_ok;
    date_s rx_next;
    logic [31:0] wr;
    logic [31:0] diff;
    logic signed [19:0] utc;

    function automatic logic [6:0] bcd_val(logic [8:0] f);
        return 7'(f[3:0]) + 7'(f[8:5]) * 7'h0A;
    endfunction
    function automatic logic bcd_ok(logic [8:0] f);
        return f[3:0] < 4'hA && f[8:5] < 4'hA;
    endfunction
    function automatic state_s enter_holdover(state_s x);
        state_s r;
        r = x;
        r.holdover = 1'b1;
        r.synced = 1'b0;
        if (!x.holdover)
        begin
            r.holdover_good = x.sync_secs >= SYNC_ACC_SECS;
            r.sync_secs = 12'h000;
        end
        return r;
    endfunction

    symbol_classifier #(.TICK_B(TICK_B)) classifier (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(s.wdt_fire),
        .line(is_am(s.code) ? am_env : dcls_in),
        .fast_rate(is_fast(s.code)),
        .sym_valid(cls_valid),
        .sym(cls_sym),
        .rise(cls_rise),
        .lost(cls_lost)
    );

    always_comb
    begin
        rx_s = bcd_val(s.bits[POS_SEC+:9]);
        rx_m = bcd_val(s.bits[POS_MIN+:9]);
        rx_h = bcd_val(s.bits[POS_HOUR+:9]);
        rx_doy = 9'(bcd_val(s.bits[POS_DAY+:9])) + 9'(s.bits[POS_DAY100+:2]) * 9'h064;
        rx_year = bcd_val(s.bits[POS_YEAR+:9]);
        rx_ok = bcd_ok(s.bits[POS_SEC+:9]) && bcd_ok(s.bits[POS_MIN+:9]) && bcd_ok(s.bits[POS_HOUR+:9])
            && bcd_ok(s.bits[POS_DAY+:9]) && rx_s < 7'h3C && rx_m < 7'h3C && rx_h < 7'h18
            && rx_doy != 9'h000 && rx_doy <= DAYS_YEAR + 9'h001;
        rx_next.year = has_year(s.code) ? rx_year : s.now.year;
        rx_next.doy = rx_doy;
        rx_next.sod = 17'(rx_h) * 17'h00E10 + 17'(rx_m) * 17'h0003C + 17'(rx_s);
        rx_next = tick_second(rx_next);
        diff = 32'(s.subsec) - 32'(s.since_rise);
        utc = 20'(signed'({3'h0, s.now.sod})) - 20'(signed'(s.offset)) * 20'sh0003C;
        if (utc < 20'sh0)
        begin
            utc = utc + 20'(DAY_SECS);
        end
        else if (utc >= 20'(DAY_SECS))
        begin
            utc = utc - 20'(DAY_SECS);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr[i*8+:8] = 8'h00;
        end
    end

    always_comb
    begin
        n = s;
        n.pps = 1'b0;
        n.wdt_fire = 1'b0;
        sec_tick = s.subsec == SUBSEC_W'(SEC_LEN - 1);
        n.since_rise = cls_rise ? '0 : (&s.since_rise ? s.since_rise : s.since_rise + 1'b1);
        if (sec_tick)
        begin
            n.subsec = '0;
            n.now = tick_second(s.now);
            n.pps = 1'b1;
            if (s.synced && s.sync_secs != 12'hFFF)
            begin
                n.sync_secs = s.sync_secs + 12'h001;
            end
            n.nolock_secs = (s.nolock_secs == 2'h3) ? s.nolock_secs : s.nolock_secs + 2'h1;
            if (s.nolock_secs >= NOLOCK_SECS)
            begin
                n = enter_holdover(n);
            end
        end
        else
        begin
            n.subsec = s.subsec + 1'b1;
        end
        if (cls_lost)
        begin
            n.state = HUNT;
        end
        if (cls_valid)
        begin
            n.prev_mark = cls_sym == SYM_MARK;
            if (s.state == HUNT || s.idx == 7'h00)
            begin
                if (cls_sym == SYM_MARK && (s.prev_mark || s.state == FRAME))
                begin
                    n.state = FRAME;
                    n.idx = 7'h01;
                    n.frm_err = 1'b0;
                end
                else if (s.state == FRAME)
                begin
                    n.state = HUNT;
                    n.check_err = 1'b1;
                    n = enter_holdover(n);
                end
                if (s.state == FRAME && cls_sym == SYM_MARK)
                begin
                    if (!s.frm_err && rx_ok)
                    begin
                        n.check_err = 1'b0;
                        n.nolock_secs = 2'h0;
                        n.subsec = s.since_rise;
                        n.phase_ok = diff <= 32'(PHASE_TOL_CYCLES) || diff >= 32'(SEC_LEN - PHASE_TOL_CYCLES);
                        n.sbs = has_sbs(s.code) ? {s.bits[POS_SBS_HI+:8], s.bits[POS_SBS_LO+:9]} : 17'h00000;
                        n.cf = 23'h000000;
                        if (is_ieee(s.code))
                        begin
                            n.cf[8:0] = {s.bits[POS_CF+8:POS_SIGN+1], s.bits[POS_SIGN] ^ (s.code == CODE_C37118),
                                s.bits[POS_CF+3:POS_CF]};
                        end
                        if (s.code == CODE_AFNOR)
                        begin
                            n.cf[22:9] = {bcd_val(s.bits[POS_AF_MON+:9]), bcd_val(s.bits[POS_AF_DOM+:9])};
                        end
                        if (!has_year(s.code) && rx_next.doy != s.now.doy)
                        begin
                            n.day_mis = 1'b1;
                            n = enter_holdover(n);
                        end
                        else
                        begin
                            n.day_mis = 1'b0;
                            n.now = rx_next;
                            n.holdover = 1'b0;
                            n.synced = 1'b1;
                        end
                    end
                    else
                    begin
                        n.check_err = 1'b1;
                        n = enter_holdover(n);
                    end
                end
            end
            else
            begin
                n.bits[s.idx] = cls_sym == SYM_ONE;
                if ((cls_sym == SYM_MARK) != ((s.idx % 7'h0A) == 7'h09))
                begin
                    n.frm_err = 1'b1;
                end
                n.idx = (s.idx == LAST_IDX) ? 7'h00 : s.idx + 7'h01;
            end
        end
        n.ack = cyc_i && stb_i && !s.ack;
        if (n.ack)
        begin
            unique case (adr_i)
                REG_CTRL: n.rdata = 32'(s.code);
                REG_OFFSET: n.rdata = 32'(s.offset);
                REG_STATUS: n.rdata = 32'({cls_lost, s.phase_ok, s.day_mis, s.check_err,
                    s.holdover_good, s.holdover, s.synced});
                REG_TIME: n.rdata = 32'(s.now.sod);
                REG_DATE: n.rdata = (32'(s.now.year) << DATE_YEAR_POS) | 32'(s.now.doy);
                REG_CF: n.rdata = 32'(s.cf);
                REG_SBS: n.rdata = 32'(s.sbs);
                REG_UTC: n.rdata = 32'(utc[16:0]);
                default: n.rdata = 32'h00000000;
            endcase
        end
        n.wdt_cnt = s.wdt_cnt + 32'h00000001;
        if (s.ack && cyc_i && stb_i && we_i)
        begin
            unique case (adr_i)
                REG_CTRL:
                begin
                    if (sel_i[0] && dat_i[3:0] <= 4'(CODE_C37118))
                    begin
                        n.code = code_e'(dat_i[3:0]);
                        n.state = HUNT;
                    end
                end
                REG_OFFSET:
                begin
                    n.offset[7:0] = sel_i[0] ? dat_i[7:0] : s.offset[7:0];
                    n.offset[15:8] = sel_i[1] ? dat_i[15:8] : s.offset[15:8];
                end
                REG_TIME:
                begin
                    if (&sel_i[2:0] && dat_i[16:0] < DAY_SECS)
                    begin
                        n.now.sod = dat_i[16:0];
                        n.subsec = '0;
                    end
                end
                REG_DATE:
                begin
                    if (&sel_i[2:0])
                    begin
                        n.now.doy = dat_i[8:0];
                        n.now.year = dat_i[DATE_YEAR_POS+:7];
                    end
                end
                REG_WDT: n.wdt_cnt = 32'h00000000;
                default: n.wdt_cnt = n.wdt_cnt | wr;
            endcase
        end
        if (s.wdt_cnt >= 32'(WDT_LEN - 1))
        begin
            n = '0;
            n.now = s.now;
            n.subsec = s.subsec;
            n.wdt_fire = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign dat_o = s.rdata;
    assign ack_o = s.ack;
    assign pps = s.pps;
    assign synced = s.synced;
    assign holdover = s.holdover;
    assign wdt_reset = s.wdt_fire;
endmodule

// >>> include/irig_pkg.sv
// Purpose: Shared constants, types and helpers for the time code decoder.
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register access.
// Notes: Register offsets are byte addresses of aligned words.
package irig_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEC_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam int TICK_A_NS = 10_000;
    localparam int TICK_A_CYCLES = TICK_A_NS / CLK_PERIOD_NS;
    localparam int TICK_B_NS = 100_000;
    localparam int TICK_B_CYCLES = TICK_B_NS / CLK_PERIOD_NS;
    localparam int PHASE_TOL_NS = 5_000;
    localparam int PHASE_TOL_CYCLES = PHASE_TOL_NS / CLK_PERIOD_NS;
    localparam int WDT_TIMEOUT_NS = 1_000_000_000;
    localparam int WDT_CYCLES = WDT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int SUBSEC_W = 27;
    localparam int TICK_W = 14;
    localparam logic [6:0] ZERO_MAX = 7'h23;
    localparam logic [6:0] ONE_MAX = 7'h41;
    localparam logic [7:0] LOST_TICKS = 8'hFA;
    localparam logic [11:0] SYNC_ACC_SECS = 12'hE10;
    localparam logic [1:0] NOLOCK_SECS = 2'h2;
    localparam logic [16:0] DAY_SECS = 17'h15180;
    localparam logic [8:0] DAYS_YEAR = 9'h16D;
    localparam logic [6:0] LAST_IDX = 7'h63;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OFFSET = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TIME = 8'h0C;
    localparam logic [7:0] REG_DATE = 8'h10;
    localparam logic [7:0] REG_CF = 8'h14;
    localparam logic [7:0] REG_SBS = 8'h18;
    localparam logic [7:0] REG_UTC = 8'h1C;
    localparam logic [7:0] REG_WDT = 8'h20;
    localparam int DATE_YEAR_POS = 16;
    localparam int POS_SEC = 1;
    localparam int POS_MIN = 10;
    localparam int POS_HOUR = 20;
    localparam int POS_DAY = 30;
    localparam int POS_DAY100 = 40;
    localparam int POS_YEAR = 50;
    localparam int POS_CF = 60;
    localparam int POS_SIGN = 64;
    localparam int POS_SBS_LO = 80;
    localparam int POS_SBS_HI = 90;
    localparam int POS_AF_MON = 60;
    localparam int POS_AF_DOM = 70;

    typedef enum logic [3:0] {
        CODE_A133, CODE_A132, CODE_A003, CODE_A002, CODE_B123, CODE_B122, CODE_B003, CODE_B002,
        CODE_B007, CODE_B006, CODE_B127, CODE_B126, CODE_AFNOR, CODE_IEEE1344, CODE_C37118
    } code_e;
    typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_MARK} sym_e;
    typedef struct packed {
        logic [6:0] year;
        logic [8:0] doy;
        logic [16:0] sod;
    } date_s;

    function automatic logic is_am(code_e c);
        return c inside {CODE_A133, CODE_A132, CODE_B123, CODE_B122, CODE_B127, CODE_B126,
                         CODE_AFNOR, CODE_IEEE1344, CODE_C37118};
    endfunction
    function automatic logic is_fast(code_e c);
        return c inside {CODE_A133, CODE_A132, CODE_A003, CODE_A002};
    endfunction
    function automatic logic has_sbs(code_e c);
        return c inside {CODE_A133, CODE_A003, CODE_B123, CODE_B003, CODE_B007, CODE_B127,
                         CODE_AFNOR, CODE_IEEE1344, CODE_C37118};
    endfunction
    function automatic logic has_year(code_e c);
        return c inside {CODE_B007, CODE_B006, CODE_B127, CODE_B126, CODE_AFNOR,
                         CODE_IEEE1344, CODE_C37118};
    endfunction
    function automatic logic is_ieee(code_e c);
        return c inside {CODE_IEEE1344, CODE_C37118};
    endfunction
    function automatic date_s tick_second(date_s d);
        date_s r;
        r = d;
        if (d.sod >= DAY_SECS - 17'h00001)
        begin
            r.sod = 17'h00000;
            if (d.doy >= DAYS_YEAR + 9'((d.year[1:0] == 2'h0) ? 1 : 0))
            begin
                r.doy = 9'h001;
                r.year = (d.year >= 7'h63) ? 7'h00 : d.year + 7'h01;
            end
            else
            begin
                r.doy = d.doy + 9'h001;
            end
        end
        else
        begin
            r.sod = d.sod + 17'h00001;
        end
        return r;
    endfunction
endpackage

// >>> core/symbol_classifier.sv
// Purpose: Measures high-pulse widths of the selected code line and classifies symbols.
// Assumes: Line is synchronous to clk_sys; width counted in hundredths of a bit period.
// Notes: Outputs are registered; lost rises after two and a half silent bit periods.
`timescale 1ns/1ns
module symbol_classifier
    import irig_pkg::*;
#(
    parameter int TICK_B = TICK_B_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic line,
    input wire logic fast_rate,
    output logic sym_valid,
    output sym_e sym,
    output logic rise,
    output logic lost
);
    typedef struct packed {
        logic line_d;
        logic [TICK_W-1:0] tick_cnt;
        logic [6:0] width;
        logic [7:0] idle;
        logic sym_valid;
        sym_e sym;
        logic rise;
        logic lost;
    } cls_s;

    cls_s s;
    cls_s n;
    logic tick;

    always_comb
    begin
        n = s;
        n.sym_valid = 1'b0;
        n.rise = 1'b0;
        n.line_d = line;
        tick = s.tick_cnt == (fast_rate ? TICK_W'(TICK_A_CYCLES - 1) : TICK_W'(TICK_B - 1));
        n.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;
        if (tick && s.idle != 8'hFF)
        begin
            n.idle = s.idle + 8'h01;
        end
        if (s.idle >= LOST_TICKS)
        begin
            n.lost = 1'b1;
        end
        if (line && !s.line_d)
        begin
            n.rise = 1'b1;
            n.width = 7'h00;
            n.idle = 8'h00;
            n.lost = 1'b0;
        end
        else if (line && tick && s.width != 7'h7F)
        begin
            n.width = s.width + 7'h01;
        end
        if (!line && s.line_d)
        begin
            n.sym_valid = 1'b1;
            if (s.width < ZERO_MAX)
            begin
                n.sym = SYM_ZERO;
            end
            else if (s.width < ONE_MAX)
            begin
                n.sym = SYM_ONE;
            end
            else
            begin
                n.sym = SYM_MARK;
            end
        end
        if (clear)
        begin
            n = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign sym_valid = s.sym_valid;
    assign sym = s.sym;
    assign rise = s.rise;
    assign lost = s.lost;
endmodule

// >>> verification/irig_decoder_properties.sv
// Purpose: Port assertions for the time code decoder.
// Assumes: Bound to the decoder top module.
// Notes: Bus, pulse and watchdog timing; holdover clear when sync rises.
`timescale 1ns/1ns
module irig_decoder_properties
    import irig_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic am_env,
    input wire logic dcls_in,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic pps,
    input wire logic synced,
    input wire logic holdover,
    input wire logic wdt_reset
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_rd_far;
        ack_o && !$past(we_i) && $past(adr_i) > REG_WDT;
    endsequence
    a_ack_after_req: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (s_rd_far |-> dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_pps_spacing: assert property (pps |=> !pps [*8])
        else $error("second pulses too close");
    a_wdt_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog pulse too long");
    a_wdt_clears: assert property (wdt_reset |=> !synced && !holdover)
        else $error("state kept after watchdog");
    a_sync_clears_hold: assert property ($rose(synced) |-> !holdover)
        else $error("holdover while newly synced");
endmodule
bind irig_time_code_decoder irig_decoder_properties u_props (
    .clk_sys(clk_sys), .resetn(resetn), .am_env(am_env), .dcls_in(dcls_in),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pps(pps), .synced(synced),
    .holdover(holdover), .wdt_reset(wdt_reset)
);

// >>> verification/tc_generator_model.sv
// Purpose: Level-shift time code source, 12:34:ss on day 100.
// Assumes: One frame of 100 bits per second.
// Notes: Line rests low while disabled; bad sends hour 25.
`timescale 1ns/1ns
module tc_generator_model
#(
    parameter int BIT_LEN = 200
)
(
    input wire logic clk_sys,
    input wire logic en,
    input wire logic bad,
    output logic line = 1'b0,
    output logic [16:0] cur_sod = 17'h00000
);
    logic [99:0] v = '0;
    logic [16:0] s;
    int cnt = 0;
    int idx = 0;
    int k = 0;
    int w;
    function automatic logic [99:0] put(input logic [99:0] f, input int p, input int x);
        f[p+:4] = 4'(x % 10);
        f[p+5+:4] = 4'((x / 10) % 10);
        f[p+10+:2] = 2'(x / 100);
        return f;
    endfunction
    always @(posedge clk_sys)
    begin
        if (!en)
        begin
            line <= 1'b0;
            cnt <= 0;
            idx <= 0;
        end
        else
        begin
            if (cnt == 0 && idx == 0)
            begin
                s = 17'((bad ? 25 : 12) * 3600 + 2050 + k);
                v = put(put(put(put('0, 1, 10 + k), 10, 34), 20, bad ? 25 : 12), 30, 100);
                v[88:80] = s[8:0];
                v[97:90] = s[16:9];
                cur_sod <= s;
            end
            w = (idx == 0 || idx % 10 == 9) ? BIT_LEN * 4 / 5 : (v[idx] ? BIT_LEN / 2 : BIT_LEN / 5);
            line <= (cnt < w);
            cnt <= (cnt == BIT_LEN - 1) ? 0 : cnt + 1;
            if (cnt == BIT_LEN - 1)
            begin
                idx <= (idx == 99) ? 0 : idx + 1;
                k <= (idx == 99) ? k + 1 : k;
            end
        end
    end
endmodule

// >>> verification/irig_time_code_decoder_tb_top.sv
// Purpose: Register, sync, rejection, loss and watchdog tests.
// Assumes: Shortened second of 20000 cycles, tick of 2 cycles.
// Notes: Modulated input toggles throughout and must be ignored.
`timescale 1ns/1ns
module irig_time_code_decoder_tb_top
    import irig_pkg::*;
;
    logic clk_sys = 0, resetn = 0, cyc_i = 0, stb_i = 0, we_i = 0, am_env = 0;
    logic en = 0, bad = 0, kick = 0, ack_o, pps, synced, holdover, wdt_reset, line;
    logic [7:0] adr_i = 8'h00, ncnt = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000, dat_o, q;
    logic [16:0] cur_sod;
    int err_total = 0;
    int compares = 0;
    int gap = 0;
    int last_gap = 0;
    irig_time_code_decoder #(.SEC_LEN(20000), .TICK_B(2), .WDT_LEN(25000)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .am_env(am_env), .dcls_in(line),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pps(pps), .synced(synced),
        .holdover(holdover), .wdt_reset(wdt_reset)
    );
    tc_generator_model #(.BIT_LEN(200)) gen (
        .clk_sys(clk_sys), .en(en), .bad(bad), .line(line), .cur_sod(cur_sod)
    );
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        ncnt <= ncnt + 8'h01;
        am_env <= ncnt[4];
    end
    always @(posedge clk_sys)
    begin
        gap <= pps ? 1 : gap + 1;
        if (pps)
            last_gap <= gap;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic timeout(input string what);
        err_total++;
        $display("Error %s expected done seen timeout", what);
        tally_and_finish();
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1)
            timeout("bus ack");
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        wb(1'b0, a, 32'h00000000);
        chk(what, e, q & m);
    endtask
    function automatic logic flag(input int w);
        return (w == 0) ? synced : ((w == 1) ? holdover : wdt_reset);
    endfunction
    task automatic wait_for(input int w, input int limit, input string what);
        int n;
        n = 0;
        while (flag(w) !== 1'b1 && n < limit)
        begin
            if (kick && n % 4096 == 4095)
                wb(1'b1, REG_WDT, 32'h00000000);
            else
                @(posedge clk_sys);
            n++;
        end
        if (flag(w) !== 1'b1)
            timeout(what);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(REG_STATUS, 32'h0000007F, 32'h00000000, "status reset");
        wb(1'b1, REG_CTRL, 32'(CODE_B003));
        wb(1'b1, REG_CTRL, 32'h0000000F);
        rdchk(REG_CTRL, 32'h0000000F, 32'(CODE_B003), "code");
        wb(1'b1, REG_OFFSET, 32'h0000003C);
        rdchk(REG_OFFSET, 32'h0000FFFF, 32'h0000003C, "offset");
        wb(1'b1, REG_TIME, 32'h00015180);
        wb(1'b1, REG_TIME, 32'h00000064);
        rdchk(REG_TIME, 32'h0001FFFF, 32'h00000064, "time");
        wb(1'b1, REG_DATE, 32'h00180064);
        rdchk(REG_DATE, 32'h007F01FF, 32'h00180064, "date");
        rdchk(8'h24, 32'hFFFFFFFF, 32'h00000000, "unmapped");
        $display("Test registers done");
        kick = 1'b1;
        en <= 1'b1;
        wait_for(0, 70000, "sync");
        rdchk(REG_TIME, 32'h0001FFFF, 32'(cur_sod), "time synced");
        rdchk(REG_SBS, 32'h0001FFFF, 32'(cur_sod) - 32'd1, "sbs");
        chk("holdover", 32'h00000000, 32'(holdover));
        rdchk(REG_DATE, 32'h007F01FF, 32'h00180064, "date synced");
        rdchk(REG_UTC, 32'h0001FFFF, 32'(cur_sod) - 32'd3600, "utc");
        $display("Test sync done");
        bad <= 1'b1;
        wait_for(1, 45000, "rejection");
        rdchk(REG_STATUS, 32'h0000000A, 32'h0000000A, "check error");
        $display("Test rejection done");
        en <= 1'b0;
        repeat (700) @(posedge clk_sys);
        rdchk(REG_STATUS, 32'h00000042, 32'h00000042, "line lost");
        chk("pps period", 32'd20000, 32'(last_gap));
        $display("Test loss done");
        kick = 1'b0;
        wait_for(2, 30000, "watchdog");
        rdchk(REG_CTRL, 32'h0000000F, 32'h00000000, "code after watchdog");
        rdchk(REG_OFFSET, 32'h0000FFFF, 32'h00000000, "offset after watchdog");
        rdchk(REG_DATE, 32'h007F01FF, 32'h00180064, "date kept");
        $display("Test watchdog done");
        tally_and_finish();
    end
endmodule
